/* File: design/exp_i2c_port.sv */
/*
  serial register port of the keypad expander with its open-drain
  interrupt pin. the bus engine runs on clk_link and samples the bus
  pins; the register-side strobes and the pin logic run on clk_sys.
  assumes: a register file on clk_sys answers reg_rdata in the same
  cycle as reg_rd, and an event queue obeys queue_hold and queue_pop.
*/
`timescale 1ns/1ps

// Summary of operation
// RULE1: answer only address 0x34 or 0x30
// RULE2: write: address, pointer, data, each acknowledged
// RULE3: pointer increments after every written data byte
// RULE4: acknowledge every received byte, stop ends transfer
// RULE5: read after pointer write and repeated start
// RULE6: pointer increments per read byte, master acknowledges
// RULE7: master not-acknowledges last byte, then stop
// RULE8: works with bus clock up to 1 mhz
// RULE9: hold queue and counter updates during access
// RULE10: queue updates may lag pin by 23 us
// RULE11: pin low while any selected source active
// RULE12: mode bit: hold pin or release 50 us
// RULE13: queue reads return oldest, pop one entry
// RULE14: ignore mismatching address until next start
module exp_i2c_port #(
  parameter bit ALT_ADDR = 1'b0,
  parameter int REL_CYC = exp_pkg::REL_CYC
) (
  clk_sys,
  rst_n,
  ce,
  clk_link,
  scl_i,
  sda_i,
  sda_o,
  sda_oe_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  queue_pop,
  queue_hold,
  irq_src,
  irq_sel,
  irq_pulse_mode,
  int_o,
  int_oe_n
);
  input wire logic clk_sys; // system clock, 200 mhz
  input wire logic rst_n; // synchronous reset, active low
  input wire logic ce; // freezes the clk_sys side while low
  input wire logic clk_link; // oversampling clock of the bus side
  input wire logic scl_i; // bus clock pin level
  input wire logic sda_i; // bus data pin level
  output logic sda_o; // data pin drive value, always low
  output logic sda_oe_n; // low while pulling data low
  output logic [7:0] reg_addr; // register index of the access
  output logic [7:0] reg_wdata; // byte to write
  output logic reg_wr; // one-cycle write strobe
  output logic reg_rd; // one-cycle read strobe
  input wire logic [7:0] reg_rdata; // answer in the reg_rd cycle
  output logic queue_pop; // one-cycle pop of the oldest event
  output logic queue_hold; // level: pause queue and counter updates
  input wire logic [exp_pkg::NSRC-1:0] irq_src; // internal sources
  input wire logic [exp_pkg::NSRC-1:0] irq_sel; // pin selection
  input wire logic irq_pulse_mode; // 1: release pin after a clear
  output logic int_o; // interrupt pin drive value, always low
  output logic int_oe_n; // low while the pin is asserted

  localparam logic [6:0] MY_ADDR =
    ALT_ADDR ? exp_pkg::ADDR_ALT : exp_pkg::ADDR_MAIN;

  ////////////////////////////////////////////////////////////////////
  // link domain: reset, pin sampling, edge and condition detect

  logic lrst_n; // reset carried into clk_link
  logic [1:0] pin_s; // {scl, sda} after two flops
  logic scl_p_q; // previous synced scl
  logic sda_p_q; // previous synced sda
  logic scl_rise; // bus clock rising edge
  logic scl_fall; // bus clock falling edge
  logic bus_start; // data falls while clock high
  logic bus_stop; // data rises while clock high

  // reset synchroniser, no reset of its own
  exp_sync #(.W(1), .INIT(1'b0)) u_lrst (
    .clk(clk_link),
    .rst_n(1'b1),
    .en(1'b1),
    .d(rst_n),
    .q(lrst_n)
  );

  // pins idle high on an open-drain bus
  exp_sync #(.W(2), .INIT(2'h3)) u_pins (
    .clk(clk_link),
    .rst_n(lrst_n),
    .en(1'b1),
    .d({scl_i, sda_i}),
    .q(pin_s)
  );

  // previous levels for edge detect
  always_ff @(posedge clk_link) begin
    if (!lrst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= pin_s[1];
      sda_p_q <= pin_s[0];
    end
  end

  // oversampling at 166 mhz resolves 1 mhz timing, see RULE8
  assign scl_rise = pin_s[1] & ~scl_p_q;
  assign scl_fall = ~pin_s[1] & scl_p_q;
  assign bus_start = pin_s[1] & scl_p_q & sda_p_q & ~pin_s[0];
  assign bus_stop = pin_s[1] & scl_p_q & ~sda_p_q & pin_s[0];

  ////////////////////////////////////////////////////////////////////
  // link domain: byte engine

  exp_pkg::exp_link_st_t st_q; // engine state
  logic [3:0] bit_q; // bits seen in the current byte
  logic [7:0] sh_q; // receive shift register
  logic [7:0] tx_q; // byte being sent
  logic rw_q; // direction of the current transfer
  logic ptr_next_q; // next written byte is the pointer
  logic [7:0] ptr_q; // internal register pointer
  logic sel_q; // addressed since the last start
  logic hold_q; // queue or counter being accessed
  logic req_tgl_q; // request event toward clk_sys
  logic req_wr_q; // request is a write
  logic [7:0] req_addr_q; // request register index
  logic [7:0] req_data_q; // request write data
  logic ack_s; // answer toggle seen in clk_link
  logic [7:0] rdata_q; // read byte, stable once answered
  logic oe_n_q; // data pin enable flop
  logic ptr_in_q; // pointer inside queue or counter window

  assign ptr_in_q = (ptr_q >= exp_pkg::COUNT_REG) &&
                    (ptr_q <= exp_pkg::QUEUE_LAST);

  // state, bit count, shifting, pointer and pin drive
  always_ff @(posedge clk_link) begin
    if (!lrst_n) begin
      st_q <= exp_pkg::EXP_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'hff;
      rw_q <= 1'b0;
      ptr_next_q <= 1'b0;
      ptr_q <= 8'h00;
      sel_q <= 1'b0;
      oe_n_q <= 1'b1;
      req_tgl_q <= 1'b0;
      req_wr_q <= 1'b0;
      req_addr_q <= 8'h00;
      req_data_q <= 8'h00;
    end else if (bus_stop) begin
      // stop ends any transfer, see RULE4 RULE7
      st_q <= exp_pkg::EXP_IDLE;
      sel_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (bus_start) begin
      // start or repeated start, see RULE1 RULE5
      st_q <= exp_pkg::EXP_ADDR;
      bit_q <= 4'h0;
      sel_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      case (st_q)
        exp_pkg::EXP_ADDR, exp_pkg::EXP_WR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], pin_s[0]};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == exp_pkg::BYTE_BITS) begin
            bit_q <= 4'h0;
            if (st_q == exp_pkg::EXP_ADDR) begin
              if (sh_q[7:1] == MY_ADDR) begin
                // own address: acknowledge, see RULE1 RULE2
                st_q <= exp_pkg::EXP_ACK;
                oe_n_q <= 1'b0;
                sel_q <= 1'b1;
                rw_q <= sh_q[0];
                ptr_next_q <= ~sh_q[0];
                if (sh_q[0]) begin
                  // fetch the first read byte early, see RULE5
                  req_tgl_q <= ~req_tgl_q;
                  req_wr_q <= 1'b0;
                  req_addr_q <= ptr_q;
                  ptr_q <= ptr_q + 8'h01;
                end
              end else begin
                // foreign address: stay off the bus, see RULE14
                st_q <= exp_pkg::EXP_SKIP;
              end
            end else begin
              // every written byte is acknowledged, see RULE4
              st_q <= exp_pkg::EXP_ACK;
              oe_n_q <= 1'b0;
              ptr_next_q <= 1'b0;
              if (ptr_next_q) begin
                ptr_q <= sh_q; // pointer byte, see RULE2
              end else begin
                // data byte to ptr, then advance, see RULE3
                req_tgl_q <= ~req_tgl_q;
                req_wr_q <= 1'b1;
                req_addr_q <= ptr_q;
                req_data_q <= sh_q;
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
        end
        exp_pkg::EXP_ACK: begin
          // acknowledge bit ends on the falling edge
          if (scl_fall) begin
            if (rw_q) begin
              st_q <= exp_pkg::EXP_RD;
              tx_q <= {rdata_q[6:0], 1'b1};
              oe_n_q <= rdata_q[7];
            end else begin
              st_q <= exp_pkg::EXP_WR;
              oe_n_q <= 1'b1;
            end
          end
        end
        exp_pkg::EXP_RD: begin
          // shift out msb first, see RULE5
          if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == exp_pkg::BYTE_BITS) begin
              st_q <= exp_pkg::EXP_MACK;
              bit_q <= 4'h0;
              oe_n_q <= 1'b1;
            end else begin
              oe_n_q <= tx_q[7];
              tx_q <= {tx_q[6:0], 1'b1};
            end
          end
        end
        exp_pkg::EXP_MACK: begin
          if (scl_rise) begin
            if (pin_s[0]) begin
              // not-acknowledge: last byte, wait for stop, see RULE7
              st_q <= exp_pkg::EXP_SKIP;
            end else begin
              // acknowledged: fetch next, advance, see RULE6
              req_tgl_q <= ~req_tgl_q;
              req_wr_q <= 1'b0;
              req_addr_q <= ptr_q;
              ptr_q <= ptr_q + 8'h01;
            end
          end else if (scl_fall) begin
            st_q <= exp_pkg::EXP_RD;
            tx_q <= {rdata_q[6:0], 1'b1};
            oe_n_q <= rdata_q[7];
          end
        end
        exp_pkg::EXP_SKIP, exp_pkg::EXP_IDLE: begin
          oe_n_q <= 1'b1; // released until the next start
        end
        default: begin
          st_q <= exp_pkg::EXP_IDLE;
          oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // hold while addressed with pointer on queue or counter
  always_ff @(posedge clk_link) begin
    if (!lrst_n) begin
      hold_q <= 1'b0;
    end else if (bus_stop) begin
      hold_q <= 1'b0; // pending updates resume, see RULE9
    end else if (sel_q && ptr_in_q) begin
      hold_q <= 1'b1; // see RULE9
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_q;

  ////////////////////////////////////////////////////////////////////
  // system domain: request handshake and register strobes

  logic req_s; // request toggle after two flops
  logic req_seen_q; // last request toggle served
  logic ack_tgl_q; // answer toggle toward clk_link
  logic hold_s; // hold level in clk_sys
  logic wr_q; // write strobe flop
  logic rd_q; // read strobe flop
  logic pop_q; // pop strobe flop
  logic [7:0] addr_q; // index of the current access
  logic [7:0] wdata_q; // write data of the current access
  logic [7:0] rdata_sys_q; // captured read answer

  // request toggle and hold level into clk_sys
  exp_sync #(.W(2), .INIT(2'h0)) u_to_sys (
    .clk(clk_sys),
    .rst_n(rst_n),
    .en(ce),
    .d({req_tgl_q, hold_q}),
    .q({req_s, hold_s})
  );

  // answer toggle into clk_link, data already stable
  exp_sync #(.W(1), .INIT(1'b0)) u_to_link (
    .clk(clk_link),
    .rst_n(lrst_n),
    .en(1'b1),
    .d(ack_tgl_q),
    .q(ack_s)
  );

  // read byte crosses as a word held stable by the handshake
  always_ff @(posedge clk_link) begin
    if (!lrst_n) begin
      rdata_q <= 8'hff;
    end else if (ack_s == req_tgl_q) begin
      rdata_q <= rdata_sys_q;
    end
  end

  // strobes one cycle after a new request, answer the cycle after
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      req_seen_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      pop_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_sys_q <= 8'hff;
    end else if (ce) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      pop_q <= 1'b0;
      if (req_s != req_seen_q) begin
        req_seen_q <= req_s;
        wr_q <= req_wr_q;
        rd_q <= ~req_wr_q;
        // queue reads consume the oldest entry, see RULE13
        pop_q <= ~req_wr_q && (req_addr_q >= exp_pkg::QUEUE_FIRST) &&
                 (req_addr_q <= exp_pkg::QUEUE_LAST);
        addr_q <= req_addr_q;
        wdata_q <= req_data_q;
      end
      if (wr_q || rd_q) begin
        if (rd_q) begin
          rdata_sys_q <= reg_rdata;
        end
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  assign reg_wr = wr_q;
  assign reg_rd = rd_q;
  assign queue_pop = pop_q;
  assign reg_addr = addr_q;
  assign reg_wdata = wdata_q;
  // outside queue applies updates within 23 us of release, see RULE10
  assign queue_hold = hold_s;

  ////////////////////////////////////////////////////////////////////
  // system domain: interrupt pin

  logic [exp_pkg::NSRC-1:0] act; // selected active sources
  logic [exp_pkg::NSRC-1:0] act_p_q; // previous selected sources
  logic [31:0] rel_q; // release countdown in pulse mode
  logic int_oe_n_q; // interrupt pin enable flop

  assign act = irq_src & irq_sel;

  // countdown starts when one of several sources clears
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      act_p_q <= '0;
      rel_q <= 32'h0;
      int_oe_n_q <= 1'b1;
    end else if (ce) begin
      act_p_q <= act;
      if (irq_pulse_mode && (|(act_p_q & ~act)) && (|act)) begin
        rel_q <= 32'(REL_CYC); // release for 50 us, see RULE12
      end else if (rel_q != 32'h0) begin
        rel_q <= rel_q - 32'h1;
      end
      // low while a selected source is active and rel_q is zero, see RULE11
      int_oe_n_q <= ~((|act) && (rel_q == 32'h0));
    end
  end

  assign int_o = 1'b0;
  assign int_oe_n = int_oe_n_q;
endmodule

/* File: design/exp_sync.sv */
/*
  two flip-flop synchroniser, W bits wide, with a reset value.
  assumes: each bit is a level that is stable for several cycles.
*/
`timescale 1ns/1ps
module exp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // first stage, read only by q

  // two stages, frozen while en is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else if (en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: include/exp_pkg.sv */
/*
  shared constants and types of the expander serial register port.
  assumes: clk_sys at 200 mhz, bus clock at most 1 mhz.
*/
package exp_pkg;
  // slave addresses, main part and the alternate model
  localparam logic [6:0] ADDR_MAIN = 7'h34;
  localparam logic [6:0] ADDR_ALT = 7'h30;
  // status register holding the key_event_counter
  localparam logic [7:0] COUNT_REG = 8'h02;
  // event queue window, every location reads the oldest entry
  localparam logic [7:0] QUEUE_FIRST = 8'h03;
  localparam logic [7:0] QUEUE_LAST = 8'h12;
  // interrupt pin mode and source selection registers
  localparam logic [7:0] IRQ_MODE_REG = 8'h3b;
  localparam logic [7:0] IRQ_SEL_REG = 8'h3c;
  // number of internal interrupt sources
  localparam int NSRC = 5;
  // system clock rate and bus ceiling
  localparam int SYS_MHZ = 200;
  localparam int BUS_MAX_KHZ = 1000;
  // worst queue update lag behind the pin, microseconds
  localparam int LAG_US = 23;
  // pin release time in pulse mode, microseconds and cycles
  localparam int REL_US = 50;
  localparam int REL_CYC = REL_US * SYS_MHZ;
  // bits of a byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // states of the link engine
  typedef enum logic [2:0] {
    EXP_IDLE = 3'b000,
    EXP_ADDR = 3'b001,
    EXP_ACK = 3'b010,
    EXP_WR = 3'b011,
    EXP_RD = 3'b100,
    EXP_MACK = 3'b101,
    EXP_SKIP = 3'b110
  } exp_link_st_t;
endpackage

/* File: verif/exp_host_model.sv */
/*
  bus master model: makes the bus clock at 1 mhz and drives data.
  assumes: sda_in is the wired data level with a pull-up.
*/
`timescale 1ns/1ps
module exp_host_model (
  output logic scl,
  output logic sda,
  input wire logic sda_in
);
  // half bus period in ns, 1 mhz bus
  localparam int HP = 500;
  // idle bus: clock stands still high outside frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // start or repeated start: data falls while clock high
  task automatic start();
    #(HP/2) sda = 1'b1;
    #(HP/2) scl = 1'b1;
    #HP sda = 1'b0;
    #HP scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    #(HP/2) sda = 1'b0;
    #(HP/2) scl = 1'b1;
    #HP sda = 1'b1;
    #HP;
  endtask
  // one bit: data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #(HP/2) sda = b;
    #(HP/2) scl = 1'b1;
    #(HP/2) r = sda_in;
    #(HP/2) scl = 1'b0;
  endtask
  // byte out msb first, returns ack seen
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // byte in; low ack to continue, high on the last
  task automatic get_byte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(!mack, r);
  endtask
endmodule

/* File: verif/exp_port_monitor.sv */
/*
  checker of the expander register port, bound to exp_i2c_port.
  assumes: rst_n resets both domains, ce may drop for a while.
*/
`timescale 1ns/1ps
module exp_port_monitor #(
  parameter bit ALT_ADDR = 1'b0,
  parameter int REL_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_oe_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic queue_pop,
  input wire logic queue_hold,
  input wire logic [exp_pkg::NSRC-1:0] irq_src,
  input wire logic [exp_pkg::NSRC-1:0] irq_sel,
  input wire logic irq_pulse_mode,
  input wire logic int_oe_n
);
  // any selected source active
  logic act;
  // register index of the access inside the queue window
  logic in_q;
  assign act = |(irq_src & irq_sel);
  assign in_q = reg_addr >= exp_pkg::QUEUE_FIRST &&
                reg_addr <= exp_pkg::QUEUE_LAST;
  ////////////////////////////////////////////////////////////
  // an ack low stays for at least eight link cycles
  sequence s_ack_low;
    !sda_oe_n [*8];
  endsequence
  // no strobe in the next cycle
  sequence s_quiet;
    !reg_rd && !reg_wr;
  endsequence
  ////////////////////////////////////////////////////////////
  irq_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(ce) && !$past(irq_pulse_mode)
    |-> int_oe_n == !$past(act)) else $error("pin not tracking sources");
  irq_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(ce) && !int_oe_n |-> $past(act))
    else $error("pin low with no selected source");
  rd_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd |=> s_quiet) else $error("read strobe too long");
  wr_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr |=> s_quiet) else $error("write strobe too long");
  strobe_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(reg_rd && reg_wr)) else $error("read and write together");
  pop_match_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    queue_pop == (reg_rd && in_q)) else $error("pop not with queue read");
  pop_held_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    queue_pop |-> queue_hold) else $error("pop while updates run");
  ack_hold_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    $fell(sda_oe_n) |-> s_ack_low) else $error("data drive too short");
  sda_edge_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    $changed(sda_oe_n) |-> !scl_i) else $error("data moved with clock high");
endmodule

bind exp_i2c_port exp_port_monitor #(
  .ALT_ADDR(ALT_ADDR),
  .REL_CYC(REL_CYC)
) mon_u (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .ce(ce),
  .clk_link(clk_link),
  .scl_i(scl_i),
  .sda_oe_n(sda_oe_n),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .queue_pop(queue_pop),
  .queue_hold(queue_hold),
  .irq_src(irq_src),
  .irq_sel(irq_sel),
  .irq_pulse_mode(irq_pulse_mode),
  .int_oe_n(int_oe_n)
);

/* File: verif/tb_exp_i2c_port.sv */
/*
  testbench of exp_i2c_port with a host model and a register file.
  assumes: register data is the index xor 0x5a, answered at once.
*/
`timescale 1ns/1ps
module tb_exp_i2c_port;
  localparam int REL = 20; // shortened pin release
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] irq_src = 5'h00;
  logic [4:0] irq_sel = 5'h00;
  logic irq_pulse_mode = 1'b0;
  logic ce = 1'b1; // dropped once to freeze the system side
  wire scl, host_sda, sda_o, sda_oe_n, sda_w;
  wire reg_wr, reg_rd, queue_pop, queue_hold, int_o, int_oe_n;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  int err_count = 0;
  int checks = 0;
  logic [7:0] wr_a[$];
  logic [7:0] wr_d[$];
  logic [7:0] pops = 8'h00;
  logic hold_seen = 1'b0;
  always #2.5 clk_sys = ~clk_sys;
  // link clock, phase unrelated to clk_sys
  always begin
    #1.7;
    forever #3 clk_link = ~clk_link;
  end
  // wired data line: pull-up, low if anyone pulls
  assign sda_w = host_sda & (sda_oe_n | sda_o);
  assign reg_rdata = reg_addr ^ 8'h5a;
  exp_host_model h (.scl(scl), .sda(host_sda), .sda_in(sda_w));
  exp_i2c_port #(.ALT_ADDR(1'b0), .REL_CYC(REL)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .clk_link(clk_link), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .queue_pop(queue_pop),
    .queue_hold(queue_hold), .irq_src(irq_src), .irq_sel(irq_sel),
    .irq_pulse_mode(irq_pulse_mode), .int_o(int_o),
    .int_oe_n(int_oe_n));
  ////////////////////////////////////////////////////////////
  // register-side log
  always @(posedge clk_sys) begin
    if (reg_wr) begin
      wr_a.push_back(reg_addr);
      wr_d.push_back(reg_wdata);
    end
    if (queue_pop) pops <= pops + 8'h01;
    if (queue_hold) hold_seen <= 1'b1;
  end
  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    logic a;
    h.put_byte(b, a);
    chk("ack", {7'h00, a}, {7'h00, e});
  endtask
  task automatic get(input logic m, input logic [7:0] e);
    logic [7:0] b;
    h.get_byte(m, b);
    chk("read byte", b, e);
  endtask
  ////////////////////////////////////////////////////////////
  // multibyte write from pointer 0x20
  task automatic t_write();
    h.start();
    send(8'h68, 1'b1);
    send(8'h20, 1'b1);
    for (int i = 0; i < 3; i++) send(8'ha0 + 8'(i), 1'b1);
    h.stop();
    cyc(20);
    chk("write count", 8'(wr_a.size()), 8'h03);
    for (int i = 0; i < 3; i++) begin
      chk("write addr", wr_a[i], 8'h20 + 8'(i));
      chk("write data", wr_d[i], 8'ha0 + 8'(i));
    end
    $display("write test done");
  endtask
  // read across the queue end: 0x11, 0x12 pop, 0x13 not
  task automatic t_read();
    h.start();
    send(8'h68, 1'b1);
    send(8'h11, 1'b1);
    h.start();
    send(8'h69, 1'b1);
    get(1'b1, 8'h11 ^ 8'h5a);
    get(1'b1, 8'h12 ^ 8'h5a);
    get(1'b0, 8'h13 ^ 8'h5a);
    h.stop();
    cyc(20);
    chk("pops", pops, 8'h02);
    chk("hold seen", {7'h00, hold_seen}, 8'h01);
    chk("hold after", {7'h00, queue_hold}, 8'h00);
    $display("read test done");
  endtask
  // alternate address is foreign here, nothing acked
  task automatic t_bad();
    wr_a.delete();
    h.start();
    send(8'h60, 1'b0);
    send(8'h20, 1'b0);
    h.stop();
    cyc(20);
    chk("foreign writes", 8'(wr_a.size()), 8'h00);
    $display("address test done");
  endtask
  // mask, hold mode and release mode of the pin
  task automatic t_irq();
    irq_src <= 5'h04;
    irq_sel <= 5'h03;
    cyc(4);
    chk("masked", {7'h00, int_oe_n}, 8'h01);
    irq_sel <= 5'h07;
    cyc(4);
    chk("selected", {7'h00, int_oe_n}, 8'h00);
    irq_src <= 5'h06;
    cyc(2);
    irq_src <= 5'h02;
    cyc(3);
    chk("held", {7'h00, int_oe_n}, 8'h00);
    irq_pulse_mode <= 1'b1;
    irq_src <= 5'h06;
    cyc(4);
    irq_src <= 5'h02;
    cyc(3);
    chk("released", {7'h00, int_oe_n}, 8'h01);
    cyc(REL + 5);
    chk("reasserted", {7'h00, int_oe_n}, 8'h00);
    // frozen clock enable keeps the pin asserted
    ce <= 1'b0;
    irq_src <= 5'h00;
    cyc(4);
    chk("frozen", {7'h00, int_oe_n}, 8'h00);
    ce <= 1'b1;
    cyc(3);
    chk("cleared", {7'h00, int_oe_n}, 8'h01);
    chk("int drive", {7'h00, int_o}, 8'h00);
    chk("sda drive", {7'h00, sda_o}, 8'h00);
    $display("interrupt test done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(10);
    t_write();
    t_read();
    t_bad();
    t_irq();
    finish_test();
  end
  // watchdog well beyond the expected 128 us
  initial begin
    #400000;
    err_count++;
    finish_test();
  end
endmodule
